// *** verilog/pcpa_defs.svh ***
// Constants for the port A data path and pin function control tail.
// Assumes inclusion by bare name from the design modules and the bench files.
`ifndef PCPA_DEFS_SVH
`define PCPA_DEFS_SVH

// Register indices; the Avalon word address equals the index.
`define PCPA_IDX_PA_DATA_HI 32'hfffe3800
`define PCPA_IDX_PA_DATA_LO 32'hfffe3802
`define PCPA_IDX_PA_PINS_HI 32'hfffe3810
`define PCPA_IDX_PA_PINS_LO 32'hfffe3812
`define PCPA_IDX_HIZ_CTL 32'hfffe3820
`define PCPA_IDX_DRV_CTL 32'hfffe3822
`define PCPA_IDX_GPI_EXT 32'hfffe3824
`define PCPA_IDX_PA_DIR_HI 32'hfffe3830
`define PCPA_IDX_PA_DIR_LO 32'hfffe3832

// Field positions.
`define PCPA_BIT_HIZ_LOW 0
`define PCPA_BIT_HIZ_HIGH 1
`define PCPA_BIT_PK_DRV 13
`define PCPA_BIT_PJ_DRV 15
`define PCPA_BIT_GENERAL_INPUT_ENABLE 8

// Reset values.
`define PCPA_RST_HIZ 2'h3
`define PCPA_RST_PJ_DRV 1'h1
`define PCPA_RST_PK_DRV 1'h1
`define PCPA_RST_GENERAL_INPUT_ENABLE 1'h0
`define PCPA_RST_PA_DATA 20'h00000
`define PCPA_RST_PA_DIR 20'h00000

// Writable bit masks; every other bit is reserved.
`define PCPA_WM_HIZ 16'h0003
`define PCPA_WM_DRV 16'ha000
`define PCPA_WM_GPI 16'h0100
`define PCPA_WM_PA_HI 16'h000f
`define PCPA_WM_PA_LO 16'hffff

// Widths.
`define PCPA_PA_W 20
`define PCPA_LC_W 12
`define PCPA_LC_GRP 6
`define PCPA_N_OR 4
`define PCPA_N_AND 5
`define PCPA_N_CAND 2

// Avalon response codes.
`define PCPA_RESP_OK 2'h0
`define PCPA_RESP_DECERR 2'h3

`endif

// *** verilog/pcpa_pkg.sv ***
// Types shared by the port A and pin control design.
// Assumes pcpa_defs.svh is on the include path.
package pcpa_pkg;
  typedef enum logic [0:0] {
    PCPA_BUS_IDLE = 1'b0,
    PCPA_BUS_ANS = 1'b1
  } pcpa_bus_e;
endpackage

// *** verilog/pcpa_merge.sv ***
// Merges input functions that are selected on more than one pin.
// Assumes each function has a fixed set of candidate pins, listed low pin first.
`timescale 1ns/1ns
`default_nettype none
`include "pcpa_defs.svh"
module pcpa_merge
  import pcpa_pkg::*;
(
  input wire logic [`PCPA_N_OR*`PCPA_N_CAND-1:0] or_lvl_i,
  input wire logic [`PCPA_N_OR*`PCPA_N_CAND-1:0] or_sel_i,
  input wire logic [`PCPA_N_AND*`PCPA_N_CAND-1:0] and_lvl_i,
  input wire logic [`PCPA_N_AND*`PCPA_N_CAND-1:0] and_sel_i,
  output logic [`PCPA_N_OR-1:0] or_o,
  output logic [`PCPA_N_AND-1:0] and_o
);
  // An unselected pin is neutral: low for the OR type, high for the AND type.
  always_comb begin
    or_o = '0;
    and_o = '1;
    for (int f = 0; f < `PCPA_N_OR; f++) begin
      for (int c = 0; c < `PCPA_N_CAND; c++) begin
        or_o[f] = or_o[f] | (or_lvl_i[f*`PCPA_N_CAND+c] & or_sel_i[f*`PCPA_N_CAND+c]);
      end
    end
    for (int f = 0; f < `PCPA_N_AND; f++) begin
      for (int c = 0; c < `PCPA_N_CAND; c++) begin
        and_o[f] = and_o[f] & (and_lvl_i[f*`PCPA_N_CAND+c] | ~and_sel_i[f*`PCPA_N_CAND+c]);
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/pcpa_pin_ctl.sv ***
// Port A data path with large-current, drive and general-input pin control.
// Assumes an Avalon-MM master with word addressing, and pin function selects from outside.
//
// What this block does
// - High override 0 floats PE17, PE19-23 in stop
// - Low override 0 floats PE9, PE11-15 in stop
// - Reserved control bits read zero, write zero
// - Bit 15 picks port J drive, resets high
// - Bit 13 picks port K drive, resets high
// - Bit 8 enables general input function
// - Enable acts only on general-input pins
// - Enable low gates input buffers, no shoot-through
// - Clock, receive, timer inputs merge by OR
// - Interrupt, DMA, trigger, disable, reset merge by AND
// - One output function drives all selected pins
// - Low port pin switched to edge function detects
// - General output: write drives pin, read register
// - General input: read pin, write only stores
// - Twenty pins: high bits 3-0, low bits 15-0
// - Pin-state registers read live pin levels
// - Output direction, other function: store, read register
`timescale 1ns/1ns
`default_nettype none
`include "pcpa_defs.svh"
module pcpa_pin_ctl
  import pcpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  input wire logic [`PCPA_PA_W-1:0] pa_pin_i,
  input wire logic [`PCPA_PA_W-1:0] pa_port_fn_i,
  input wire logic [`PCPA_PA_W-1:0] pa_alt_do_i,
  input wire logic [`PCPA_PA_W-1:0] pa_alt_oe_i,
  input wire logic out_fn_val_i,
  input wire logic [`PCPA_PA_W-1:0] pa_out_fn_sel_i,
  output logic [`PCPA_PA_W-1:0] pa_pin_o,
  output logic [`PCPA_PA_W-1:0] pa_pin_oe_b_o,
  output logic [`PCPA_PA_W-1:0] pa_ibuf_en_o,
  input wire logic osc_stop_i,
  input wire logic sw_standby_i,
  input wire logic [`PCPA_LC_W-1:0] pe_lc_do_i,
  input wire logic [`PCPA_LC_W-1:0] pe_lc_oe_i,
  output logic [`PCPA_LC_W-1:0] pe_lc_do_o,
  output logic [`PCPA_LC_W-1:0] pe_lc_oe_b_o,
  output logic pj_drive_low_o,
  output logic pk_drive_low_o,
  output logic general_input_enable_o,
  input wire logic [`PCPA_N_OR*`PCPA_N_CAND-1:0] or_lvl_i,
  input wire logic [`PCPA_N_OR*`PCPA_N_CAND-1:0] or_sel_i,
  input wire logic [`PCPA_N_AND*`PCPA_N_CAND-1:0] and_lvl_i,
  input wire logic [`PCPA_N_AND*`PCPA_N_CAND-1:0] and_sel_i,
  output logic [`PCPA_N_OR-1:0] merged_or_o,
  output logic [`PCPA_N_AND-1:0] merged_and_o,
  output logic [`PCPA_N_AND-1:0] and_fall_o
);
  // Byte-lane write merge limited to the writable bits of a 16-bit register.
  function automatic logic [15:0] wmerge(input logic [15:0] old_v, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [15:0] wm);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & wm;
    wmerge = (old_v & ~lane) | (wd[15:0] & lane);
  endfunction

  pcpa_bus_e bus_st_r;
  logic [1:0] hiz_r;
  logic pj_drv_r;
  logic pk_drv_r;
  logic general_input_enable_r;
  logic [`PCPA_PA_W-1:0] pa_data_r;
  logic [`PCPA_PA_W-1:0] pa_dir_r;
  logic sel_data_hi, sel_data_lo, sel_pins_hi, sel_pins_lo;
  logic sel_hiz, sel_drv, sel_gpi, sel_dir_hi, sel_dir_lo, hit;
  logic [15:0] rd_val;
  logic [`PCPA_PA_W-1:0] gen_in, gen_out, ibuf_en, pin_seen, data_rd;
  logic [`PCPA_PA_W-1:0] pin_drv, pin_oe;
  logic wr_en, stop_mode;
  logic [`PCPA_N_OR-1:0] or_now;
  logic [`PCPA_N_AND-1:0] and_now;
  logic [15:0] cur_hiz, cur_drv, cur_gpi, cur_pa_hi, cur_pa_lo;

  // Address decode.
  always_comb begin
    sel_data_hi = 1'b0;
    sel_data_lo = 1'b0;
    sel_pins_hi = 1'b0;
    sel_pins_lo = 1'b0;
    sel_hiz = 1'b0;
    sel_drv = 1'b0;
    sel_gpi = 1'b0;
    sel_dir_hi = 1'b0;
    sel_dir_lo = 1'b0;
    if (avs_address_i == `PCPA_IDX_PA_DATA_HI) begin
      sel_data_hi = 1'b1;
    end else if (avs_address_i == `PCPA_IDX_PA_DATA_LO) begin
      sel_data_lo = 1'b1;
    end else if (avs_address_i == `PCPA_IDX_PA_PINS_HI) begin
      sel_pins_hi = 1'b1;
    end else if (avs_address_i == `PCPA_IDX_PA_PINS_LO) begin
      sel_pins_lo = 1'b1;
    end else if (avs_address_i == `PCPA_IDX_HIZ_CTL) begin
      sel_hiz = 1'b1;
    end else if (avs_address_i == `PCPA_IDX_DRV_CTL) begin
      sel_drv = 1'b1;
    end else if (avs_address_i == `PCPA_IDX_GPI_EXT) begin
      sel_gpi = 1'b1;
    end else if (avs_address_i == `PCPA_IDX_PA_DIR_HI) begin
      sel_dir_hi = 1'b1;
    end else if (avs_address_i == `PCPA_IDX_PA_DIR_LO) begin
      sel_dir_lo = 1'b1;
    end
  end

  assign hit = sel_data_hi | sel_data_lo | sel_pins_hi | sel_pins_lo | sel_hiz | sel_drv |
               sel_gpi | sel_dir_hi | sel_dir_lo;

  // Pin classes; the enable touches only pins whose function is general input.
  assign gen_in = pa_port_fn_i & ~pa_dir_r;
  assign gen_out = pa_port_fn_i & pa_dir_r;
  assign ibuf_en = ~(gen_in & {`PCPA_PA_W{~general_input_enable_r}});
  assign pin_seen = pa_pin_i & ibuf_en;
  // Output direction reads the register, input direction reads the pin.
  assign data_rd = (pa_dir_r & pa_data_r) | (~pa_dir_r & pin_seen);

  assign cur_hiz = {14'h0000, hiz_r};
  assign cur_drv = {pj_drv_r, 1'b0, pk_drv_r, 13'h0000};
  assign cur_gpi = {7'h00, general_input_enable_r, 8'h00};
  assign cur_pa_hi = {12'h000, pa_data_r[19:16]};
  assign cur_pa_lo = pa_data_r[15:0];

  // Read mux; reserved and unmapped bits read zero.
  always_comb begin
    rd_val = 16'h0000;
    if (sel_data_hi) begin
      rd_val = {12'h000, data_rd[19:16]};
    end else if (sel_data_lo) begin
      rd_val = data_rd[15:0];
    end else if (sel_pins_hi) begin
      rd_val = {12'h000, pin_seen[19:16]};
    end else if (sel_pins_lo) begin
      rd_val = pin_seen[15:0];
    end else if (sel_hiz) begin
      rd_val = cur_hiz;
    end else if (sel_drv) begin
      rd_val = cur_drv;
    end else if (sel_gpi) begin
      rd_val = cur_gpi;
    end else if (sel_dir_hi) begin
      rd_val = {12'h000, pa_dir_r[19:16]};
    end else if (sel_dir_lo) begin
      rd_val = pa_dir_r[15:0];
    end
  end

  // Bus handshake: request taken in idle, answered one cycle later.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      bus_st_r <= PCPA_BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
      avs_response_o <= `PCPA_RESP_OK;
    end else begin
      case (bus_st_r)
        PCPA_BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_st_r <= PCPA_BUS_ANS;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= avs_read_i ? {16'h0000, rd_val} : 32'h00000000;
            avs_response_o <= hit ? `PCPA_RESP_OK : `PCPA_RESP_DECERR;
          end
        end
        PCPA_BUS_ANS: begin
          bus_st_r <= PCPA_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_st_r <= PCPA_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // Writes take effect at the edge where waitrequest is seen low.
  assign wr_en = (bus_st_r == PCPA_BUS_ANS) && avs_write_i;

  logic [15:0] nxt_hiz, nxt_drv, nxt_gpi, nxt_pa_hi, nxt_pa_lo, nxt_dir_hi, nxt_dir_lo;
  assign nxt_hiz = wmerge(cur_hiz, avs_writedata_i, avs_byteenable_i, `PCPA_WM_HIZ);
  assign nxt_drv = wmerge(cur_drv, avs_writedata_i, avs_byteenable_i, `PCPA_WM_DRV);
  assign nxt_gpi = wmerge(cur_gpi, avs_writedata_i, avs_byteenable_i, `PCPA_WM_GPI);
  assign nxt_pa_hi = wmerge(cur_pa_hi, avs_writedata_i, avs_byteenable_i, `PCPA_WM_PA_HI);
  assign nxt_pa_lo = wmerge(cur_pa_lo, avs_writedata_i, avs_byteenable_i, `PCPA_WM_PA_LO);
  assign nxt_dir_hi = wmerge({12'h000, pa_dir_r[19:16]}, avs_writedata_i, avs_byteenable_i, `PCPA_WM_PA_HI);
  assign nxt_dir_lo = wmerge(pa_dir_r[15:0], avs_writedata_i, avs_byteenable_i, `PCPA_WM_PA_LO);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hiz_r <= `PCPA_RST_HIZ;
      pj_drv_r <= `PCPA_RST_PJ_DRV;
      pk_drv_r <= `PCPA_RST_PK_DRV;
      general_input_enable_r <= `PCPA_RST_GENERAL_INPUT_ENABLE;
    end else if (wr_en) begin
      if (sel_hiz) begin
        hiz_r <= nxt_hiz[1:0];
      end
      if (sel_drv) begin
        pj_drv_r <= nxt_drv[`PCPA_BIT_PJ_DRV];
        pk_drv_r <= nxt_drv[`PCPA_BIT_PK_DRV];
      end
      if (sel_gpi) begin
        general_input_enable_r <= nxt_gpi[`PCPA_BIT_GENERAL_INPUT_ENABLE];
      end
    end
  end

  // Port A data and direction; a write always stores, whatever the pin function.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pa_data_r <= `PCPA_RST_PA_DATA;
      pa_dir_r <= `PCPA_RST_PA_DIR;
    end else if (wr_en) begin
      if (sel_data_hi) begin
        pa_data_r[19:16] <= nxt_pa_hi[3:0];
      end
      if (sel_data_lo) begin
        pa_data_r[15:0] <= nxt_pa_lo;
      end
      if (sel_dir_hi) begin
        pa_dir_r[19:16] <= nxt_dir_hi[3:0];
      end
      if (sel_dir_lo) begin
        pa_dir_r[15:0] <= nxt_dir_lo;
      end
    end
  end

  // Pin drive: general output first, then the shared output function, then other functions.
  always_comb begin
    pin_drv = '0;
    pin_oe = '0;
    for (int i = 0; i < `PCPA_PA_W; i++) begin
      if (gen_out[i]) begin
        pin_drv[i] = pa_data_r[i];
        pin_oe[i] = 1'b1;
      end else if (!pa_port_fn_i[i] && pa_out_fn_sel_i[i]) begin
        pin_drv[i] = out_fn_val_i;
        pin_oe[i] = 1'b1;
      end else if (!pa_port_fn_i[i]) begin
        pin_drv[i] = pa_alt_do_i[i];
        pin_oe[i] = pa_alt_oe_i[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pa_pin_o <= '0;
      pa_pin_oe_b_o <= '1;
      pa_ibuf_en_o <= '0;
    end else begin
      pa_pin_o <= pin_drv;
      pa_pin_oe_b_o <= ~pin_oe;
      pa_ibuf_en_o <= ibuf_en;
    end
  end

  // Large-current port E pins: low group is bits 5..0, high group bits 11..6.
  assign stop_mode = osc_stop_i | sw_standby_i;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pe_lc_do_o <= '0;
      pe_lc_oe_b_o <= '1;
    end else begin
      pe_lc_do_o <= pe_lc_do_i;
      pe_lc_oe_b_o[`PCPA_LC_GRP-1:0] <= (stop_mode && !hiz_r[`PCPA_BIT_HIZ_LOW]) ?
        {`PCPA_LC_GRP{1'b1}} : ~pe_lc_oe_i[`PCPA_LC_GRP-1:0];
      pe_lc_oe_b_o[`PCPA_LC_W-1:`PCPA_LC_GRP] <= (stop_mode && !hiz_r[`PCPA_BIT_HIZ_HIGH]) ?
        {`PCPA_LC_GRP{1'b1}} : ~pe_lc_oe_i[`PCPA_LC_W-1:`PCPA_LC_GRP];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pj_drive_low_o <= `PCPA_RST_PJ_DRV;
      pk_drive_low_o <= `PCPA_RST_PK_DRV;
      general_input_enable_o <= `PCPA_RST_GENERAL_INPUT_ENABLE;
    end else begin
      pj_drive_low_o <= pj_drv_r;
      pk_drive_low_o <= pk_drv_r;
      general_input_enable_o <= general_input_enable_r;
    end
  end

  // Merged inputs; a fall on an AND-type input is a real event even when caused by a selection change.
  pcpa_merge u_merge (
    .or_lvl_i(or_lvl_i),
    .or_sel_i(or_sel_i),
    .and_lvl_i(and_lvl_i),
    .and_sel_i(and_sel_i),
    .or_o(or_now),
    .and_o(and_now)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      merged_or_o <= '0;
      merged_and_o <= '1;
      and_fall_o <= '0;
    end else begin
      merged_or_o <= or_now;
      merged_and_o <= and_now;
      and_fall_o <= merged_and_o & ~and_now;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_hiz_low;
    stop_mode && !hiz_r[0] |=> (&pe_lc_oe_b_o[5:0]);
  endproperty
  a_hiz_low: assert property (p_hiz_low) else $error("low group not floated in stop");

  property p_hiz_high;
    stop_mode && !hiz_r[1] |=> (&pe_lc_oe_b_o[11:6]);
  endproperty
  a_hiz_high: assert property (p_hiz_high) else $error("high group not floated in stop");

  property p_hiz_keep;
    rst_b_i && !stop_mode |=> pe_lc_oe_b_o == ~$past(pe_lc_oe_i);
  endproperty
  a_hiz_keep: assert property (p_hiz_keep) else $error("large-current enables altered outside stop");

  property p_pj_drive;
    wr_en && sel_drv && avs_byteenable_i[1] |-> ##2 pj_drive_low_o == $past(avs_writedata_i[15], 2);
  endproperty
  a_pj_drive: assert property (p_pj_drive) else $error("port J drive not taken from bit 15");

  property p_pk_drive;
    wr_en && sel_drv && avs_byteenable_i[1] |-> ##2 pk_drive_low_o == $past(avs_writedata_i[13], 2);
  endproperty
  a_pk_drive: assert property (p_pk_drive) else $error("port K drive not taken from bit 13");

  property p_reserved_zero;
    !avs_waitrequest_o && avs_read_i && (sel_hiz || sel_drv || sel_gpi) |->
      (avs_readdata_o & ~{16'h0000, `PCPA_WM_HIZ | `PCPA_WM_DRV | `PCPA_WM_GPI}) == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one");

  property p_gen_out;
    1'b1 |=> ((pa_pin_o ^ $past(pa_data_r)) & $past(gen_out)) == '0 && (pa_pin_oe_b_o & $past(gen_out)) == '0;
  endproperty
  a_gen_out: assert property (p_gen_out) else $error("general output pin not driven from data");

  property p_gen_in_read;
    bus_st_r == PCPA_BUS_IDLE && avs_read_i && sel_data_lo |=>
      ((avs_readdata_o[15:0] ^ $past(pin_seen[15:0])) & ~$past(pa_dir_r[15:0])) == 16'h0000;
  endproperty
  a_gen_in_read: assert property (p_gen_in_read) else $error("input pin read not live level");

  property p_pin_state;
    bus_st_r == PCPA_BUS_IDLE && avs_read_i && sel_pins_lo |=> avs_readdata_o[15:0] == $past(pin_seen[15:0]);
  endproperty
  a_pin_state: assert property (p_pin_state) else $error("pin-state read mismatch");

  property p_general_input_enable_gate;
    !general_input_enable_r |=> (pa_ibuf_en_o & $past(gen_in)) == '0;
  endproperty
  a_general_input_enable_gate: assert property (p_general_input_enable_gate) else $error("input buffer open with enable low");

  property p_merge_or;
    1'b1 |=> merged_or_o[0] == $past(|(or_lvl_i[1:0] & or_sel_i[1:0]));
  endproperty
  a_merge_or: assert property (p_merge_or) else $error("OR merge wrong");

  property p_merge_and;
    1'b1 |=> merged_and_o[0] == $past(&(and_lvl_i[1:0] | ~and_sel_i[1:0]));
  endproperty
  a_merge_and: assert property (p_merge_and) else $error("AND merge wrong");

  property p_fall;
    $fell(merged_and_o[0]) |-> and_fall_o[0] ##1 !and_fall_o[0];
  endproperty
  a_fall: assert property (p_fall) else $error("merged fall not reported");

  property p_out_fn;
    1'b1 |=> ((pa_pin_o ^ {`PCPA_PA_W{$past(out_fn_val_i)}}) & $past(pa_out_fn_sel_i & ~pa_port_fn_i)) == '0;
  endproperty
  a_out_fn: assert property (p_out_fn) else $error("shared output not on every selected pin");

  property p_bus_ans;
    bus_st_r == PCPA_BUS_IDLE && (avs_read_i || avs_write_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus answer not one cycle");

  c_stop_float: cover property (stop_mode && !hiz_r[0]);
  c_general_input_enable_set: cover property (wr_en && sel_gpi && avs_writedata_i[8]);
  c_and_fall: cover property (and_fall_o[0]);
  c_decerr: cover property (!avs_waitrequest_o && avs_response_o == `PCPA_RESP_DECERR);
endmodule
`default_nettype wire

// *** tb/pcpa_board.sv ***
// Board model for port A: each pin takes the device drive, or the board level where the device floats.
// Assumes active-low output enables; a board driver set to fight overrides the device.
`timescale 1ns/1ns
`default_nettype none
`include "pcpa_defs.svh"
module pcpa_board (
  input wire logic [`PCPA_PA_W-1:0] dev_do_i,
  input wire logic [`PCPA_PA_W-1:0] dev_oe_b_i,
  input wire logic [`PCPA_PA_W-1:0] ext_lvl_i,
  input wire logic [`PCPA_PA_W-1:0] ext_fight_i,
  output logic [`PCPA_PA_W-1:0] pin_o
);
  // A fighting board wins so that a register read can be told apart from a pin read.
  always_comb begin
    for (int i = 0; i < `PCPA_PA_W; i++) begin
      pin_o[i] = (dev_oe_b_i[i] | ext_fight_i[i]) ? ext_lvl_i[i] : dev_do_i[i];
    end
  end
endmodule
`default_nettype wire

// *** tb/pin_control_ext_port_a_data_test.sv ***
// Self-checking bench for the port A data path and pin control tail.
// Assumes the board model drives the port A pins and the bench drives everything else.
`timescale 1ns/1ns
`default_nettype none
`include "pcpa_defs.svh"
module pin_control_ext_port_a_data_test;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [31:0] avs_address_i = '0, avs_writedata_i = '0, avs_readdata_o, rd_q;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
  logic [3:0] avs_byteenable_i = 4'h3;
  logic [1:0] avs_response_o, rd_rsp;
  logic [19:0] pa_pin_i, pa_port_fn_i = '0, pa_alt_do_i = '0, pa_alt_oe_i = '0, pa_out_fn_sel_i = '0;
  logic [19:0] pa_pin_o, pa_pin_oe_b_o, pa_ibuf_en_o, ext_lvl = '0, ext_fight = '0;
  logic out_fn_val_i = 1'b0, osc_stop_i = 1'b0, sw_standby_i = 1'b0;
  logic [11:0] pe_lc_do_i = 12'ha5a, pe_lc_oe_i = 12'hfff, pe_lc_do_o, pe_lc_oe_b_o;
  logic pj_drive_low_o, pk_drive_low_o, general_input_enable_o;
  logic [7:0] or_lvl_i = '0, or_sel_i = '0;
  logic [9:0] and_lvl_i = '0, and_sel_i = '0;
  logic [3:0] merged_or_o;
  logic [4:0] merged_and_o, and_fall_o;
  int n_errors = 0, comparisons = 0, cycles = 0;

  always #50 clk_i = ~clk_i;

  pcpa_pin_ctl uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pa_pin_i(pa_pin_i), .pa_port_fn_i(pa_port_fn_i),
    .pa_alt_do_i(pa_alt_do_i), .pa_alt_oe_i(pa_alt_oe_i), .out_fn_val_i(out_fn_val_i),
    .pa_out_fn_sel_i(pa_out_fn_sel_i), .pa_pin_o(pa_pin_o), .pa_pin_oe_b_o(pa_pin_oe_b_o),
    .pa_ibuf_en_o(pa_ibuf_en_o), .osc_stop_i(osc_stop_i), .sw_standby_i(sw_standby_i),
    .pe_lc_do_i(pe_lc_do_i), .pe_lc_oe_i(pe_lc_oe_i), .pe_lc_do_o(pe_lc_do_o), .pe_lc_oe_b_o(pe_lc_oe_b_o),
    .pj_drive_low_o(pj_drive_low_o), .pk_drive_low_o(pk_drive_low_o),
    .general_input_enable_o(general_input_enable_o), .or_lvl_i(or_lvl_i), .or_sel_i(or_sel_i),
    .and_lvl_i(and_lvl_i), .and_sel_i(and_sel_i), .merged_or_o(merged_or_o),
    .merged_and_o(merged_and_o), .and_fall_o(and_fall_o));

  pcpa_board board (.dev_do_i(pa_pin_o), .dev_oe_b_i(pa_pin_oe_b_o), .ext_lvl_i(ext_lvl),
    .ext_fight_i(ext_fight), .pin_o(pa_pin_i));

  task automatic results;
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      results;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request stands until waitrequest is sampled low; data and response are taken at that edge.
  task automatic bus(input logic wr_en, input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_write_i <= wr_en;
    avs_read_i <= !wr_en;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd_q = avs_readdata_o;
    rd_rsp = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(rd_q, {16'h0000, e});
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic t_reset;
    rd_chk(`PCPA_IDX_HIZ_CTL, 16'h0003);
    rd_chk(`PCPA_IDX_DRV_CTL, 16'ha000);
    rd_chk(`PCPA_IDX_GPI_EXT, 16'h0000);
    chk({29'h0, pj_drive_low_o, pk_drive_low_o, general_input_enable_o}, 32'h6);
    bus(1'b0, 32'hfffe3804, 16'h0000);
    chk(rd_q, 32'h0);
    chk_rsp(rd_rsp, `PCPA_RESP_DECERR);
  endtask

  task automatic t_reserved;
    wr(`PCPA_IDX_HIZ_CTL, 16'hffff);
    rd_chk(`PCPA_IDX_HIZ_CTL, 16'h0003);
    wr(`PCPA_IDX_DRV_CTL, 16'h8000);
    settle;
    chk({30'h0, pj_drive_low_o, pk_drive_low_o}, 32'h2);
    wr(`PCPA_IDX_DRV_CTL, 16'hffff);
    rd_chk(`PCPA_IDX_DRV_CTL, 16'ha000);
    wr(`PCPA_IDX_GPI_EXT, 16'hffff);
    rd_chk(`PCPA_IDX_GPI_EXT, 16'h0100);
    chk_rsp(rd_rsp, `PCPA_RESP_OK);
    wr(`PCPA_IDX_DRV_CTL, 16'h0000);
    wr(`PCPA_IDX_GPI_EXT, 16'h0000);
    settle;
    chk({30'h0, pj_drive_low_o, pk_drive_low_o}, 32'h0);
  endtask

  task automatic t_out;
    pa_port_fn_i <= 20'hfffff;
    ext_fight <= 20'hfffff;
    ext_lvl <= 20'ha5a3c;
    wr(`PCPA_IDX_PA_DIR_HI, 16'h000f);
    wr(`PCPA_IDX_PA_DIR_LO, 16'hffff);
    wr(`PCPA_IDX_PA_DATA_LO, 16'ha5c3);
    wr(`PCPA_IDX_PA_DATA_HI, 16'hfff5);
    settle;
    chk({12'h0, pa_pin_o}, 32'h5a5c3);
    chk({12'h0, pa_pin_oe_b_o}, 32'h0);
    rd_chk(`PCPA_IDX_PA_DATA_LO, 16'ha5c3);
    rd_chk(`PCPA_IDX_PA_DATA_HI, 16'h0005);
    rd_chk(`PCPA_IDX_PA_PINS_LO, 16'h5a3c);
    rd_chk(`PCPA_IDX_PA_PINS_HI, 16'h000a);
    ext_fight <= 20'h0;
  endtask

  task automatic t_in;
    pa_port_fn_i <= 20'h0ffff;
    ext_lvl <= 20'h93c5a;
    wr(`PCPA_IDX_PA_DIR_HI, 16'h0000);
    wr(`PCPA_IDX_PA_DIR_LO, 16'h0000);
    settle;
    chk({12'h0, pa_ibuf_en_o}, 32'hf0000);
    rd_chk(`PCPA_IDX_PA_DATA_LO, 16'h0000);
    rd_chk(`PCPA_IDX_PA_DATA_HI, 16'h0009);
    wr(`PCPA_IDX_GPI_EXT, 16'h0100);
    rd_chk(`PCPA_IDX_GPI_EXT, 16'h0100);
    settle;
    chk({12'h0, pa_ibuf_en_o}, 32'hfffff);
    chk({31'h0, general_input_enable_o}, 32'h1);
    rd_chk(`PCPA_IDX_PA_DATA_LO, 16'h3c5a);
    wr(`PCPA_IDX_PA_DATA_LO, 16'hffff);
    settle;
    chk({12'h0, pa_pin_oe_b_o}, 32'hfffff);
    rd_chk(`PCPA_IDX_PA_PINS_LO, 16'h3c5a);
  endtask

  task automatic t_other;
    pa_port_fn_i <= 20'h0;
    pa_out_fn_sel_i <= 20'h00021;
    out_fn_val_i <= 1'b1;
    pa_alt_oe_i <= 20'h00080;
    pa_alt_do_i <= 20'h00080;
    wr(`PCPA_IDX_PA_DIR_LO, 16'hffff);
    wr(`PCPA_IDX_PA_DATA_LO, 16'h1234);
    settle;
    chk({12'h0, pa_pin_oe_b_o}, 32'hfff5e);
    chk({12'h0, pa_pin_o & 20'h000a1}, 32'ha1);
    rd_chk(`PCPA_IDX_PA_DATA_LO, 16'h1234);
  endtask

  task automatic t_hiz;
    for (int h = 0; h < 4; h++) begin
      wr(`PCPA_IDX_HIZ_CTL, h[15:0]);
      for (int s = 0; s < 3; s++) begin
        osc_stop_i <= (s == 1);
        sw_standby_i <= (s == 2);
        settle;
        chk({20'h0, pe_lc_oe_b_o}, {20'h0, {6{(s != 0) && !h[1]}}, {6{(s != 0) && !h[0]}}});
      end
    end
    wr(`PCPA_IDX_HIZ_CTL, 16'h0003);
    chk({20'h0, pe_lc_do_o}, 32'ha5a);
  endtask

  task automatic t_merge(input logic [7:0] ol, input logic [7:0] os, input logic [9:0] al,
                         input logic [9:0] as);
    logic [3:0] eo;
    logic [4:0] ea;
    for (int f = 0; f < 4; f++) eo[f] = |(ol[2*f+:2] & os[2*f+:2]);
    for (int f = 0; f < 5; f++) ea[f] = &(al[2*f+:2] | ~as[2*f+:2]);
    or_lvl_i <= ol;
    or_sel_i <= os;
    and_lvl_i <= al;
    and_sel_i <= as;
    settle;
    chk({28'h0, merged_or_o}, {28'h0, eo});
    chk({27'h0, merged_and_o}, {27'h0, ea});
  endtask

  task automatic t_edge;
    int cnt;
    cnt = 0;
    t_merge(8'h00, 8'h00, 10'h000, 10'h000);
    and_sel_i <= 10'h001;
    repeat (6) begin
      @(posedge clk_i);
      if (and_fall_o[0] === 1'b1) cnt++;
    end
    chk(cnt, 32'h1);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_reserved;
    t_out;
    t_in;
    t_other;
    t_hiz;
    t_merge(8'b01100011, 8'hff, 10'b1101101100, 10'h3ff);
    t_merge(8'b01100011, 8'h55, 10'b1101101100, 10'h155);
    t_edge;
    results;
  end
endmodule
`default_nettype wire
